// >>> logic/timer_pkg.sv
// ----------------------------------------------------------------------------
// timer constants, register map and carrier types
// ----------------------------------------------------------------------------
package timer_pkg;

  // --------------------------------------------------------------------------
  // clocking
  // --------------------------------------------------------------------------
  // system clock period
  localparam int CLK_PERIOD_NS = 25;
  // watch clock period, a plain default
  localparam int WATCH_PERIOD_NS = 30500;
  // system cycles per watch clock cycle, rounded down
  localparam int WATCH_DIV_CYCLES = WATCH_PERIOD_NS / CLK_PERIOD_NS;
  // divided system clock ratio
  localparam int SYS_DIV_CYCLES = 8;
  // watch ticks per count tick in the quarter watch rate
  localparam int WATCH_QUARTER = 4;
  // widths in watch cycles of the event signals
  localparam logic [1:0] WATCH_EVT_TICKS = 2'h2;
  localparam logic [1:0] WATCH_ISRC_TICKS = 2'h1;

  // --------------------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_OUTCTL = 5'h04;
  localparam logic [4:0] OFS_COUNT = 5'h08;
  localparam logic [4:0] OFS_COMPARE = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_CLEAR = 5'h14;
  localparam logic [4:0] OFS_IRQ_EN = 5'h18;

  // --------------------------------------------------------------------------
  // field positions and reset values
  // --------------------------------------------------------------------------
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_TOGGLE_BIT = 1;
  localparam int CTRL_SEL_LSB = 2;
  localparam int CTRL_SUBACT_BIT = 4;
  localparam int OUTCTL_LEVEL_BIT = 0;
  localparam int ST_OVF_BIT = 0;
  localparam int ST_CMP_BIT = 1;
  localparam int ST_IRQ_BIT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'hFF;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [2:0] FLAGS_RESET = 3'h0;

  // count clock source
  typedef enum logic [1:0] {
    CLK_SYS = 2'h0,
    CLK_SYS_DIV = 2'h1,
    CLK_WATCH_QUARTER = 2'h2,
    CLK_STOPPED = 2'h3
  } clk_sel_e;

  // timer events of one cycle, in status bit order
  typedef struct packed {
    logic isrc;
    logic cmp;
    logic ovf;
  } timer_evt_s;

endpackage : timer_pkg

// >>> logic/count_clock_gen.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// count clock enables from the single system clock
// ----------------------------------------------------------------------------
module count_clock_gen
  import timer_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic run_in,
  input clk_sel_e sel_in,
  output logic count_tick_out,
  output logic watch_tick_out
);

  // watch divider and sub-dividers
  logic [11:0] watch_cnt_reg;
  logic [2:0] sys_cnt_reg;
  logic [1:0] quarter_cnt_reg;
  logic watch_now;

  assign watch_now = (watch_cnt_reg == 12'(WATCH_DIV_CYCLES - 1));

  // free running watch clock enable
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      watch_cnt_reg <= 12'h000;
      watch_tick_out <= 1'b0;
    end else begin
      watch_cnt_reg <= watch_now ? 12'h000 : watch_cnt_reg + 12'h001;
      watch_tick_out <= watch_now;
    end
  end

  // divided system rate and quarter watch rate
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sys_cnt_reg <= 3'h0;
      quarter_cnt_reg <= 2'h0;
      count_tick_out <= 1'b0;
    end else begin
      sys_cnt_reg <= sys_cnt_reg + 3'h1;
      if (watch_now) begin
        quarter_cnt_reg <= quarter_cnt_reg + 2'h1;
      end
      // a stopped clock gives no edge at all
      unique case (sel_in)
        CLK_SYS: count_tick_out <= run_in;
        CLK_SYS_DIV: count_tick_out <= run_in && (sys_cnt_reg == 3'(SYS_DIV_CYCLES - 1));
        CLK_WATCH_QUARTER: count_tick_out <= run_in && watch_now &&
                                             (quarter_cnt_reg == 2'(WATCH_QUARTER - 1));
        CLK_STOPPED: count_tick_out <= 1'b0;
      endcase
    end
  end

endmodule : count_clock_gen

// >>> logic/timer_compare_overflow_contention.sv
`timescale 1ns/1ps
// Operation
// - toggle pin inverts on each compare match
// - output control write beats same-cycle toggle
// - compare value write suppresses that match
// - equal new compare data: either outcome
// - match only on count clock edges
// - counter write suppresses same-cycle overflow
// - watch rate: source 1, events 2 wide
// - active mode: irq clear during source pulse keeps flag set
// - active mode: no flag clear while valid
// - subactive mode clears flags any time
module timer_compare_overflow_contention
  import timer_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic [4:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  output logic LOW_HALF_TOGGLE_OUT_PIN_OUT,
  output logic IRQ_OUT
);

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  logic [7:0] ctrl_reg; // run, toggle, source, subactive
  logic low_half_out_level_bit; // output_control_reg level bit
  logic [7:0] low_half_counter; // counting register
  logic [7:0] low_half_compare_value; // compare register
  logic [2:0] flags_reg; // timer_control_status_reg sticky flags
  logic [2:0] flags_next;
  logic [2:0] irq_en_reg; // interrupt enables, same layout
  logic [1:0] ovf_left_reg; // watch cycles left of overflow signal
  logic [1:0] cmp_left_reg; // watch cycles left of match signal
  logic [1:0] isrc_left_reg; // watch cycles left of source pulse
  logic wr_fire; // write taken at this edge
  logic lane0; // low byte lane enabled
  logic wr_ctrl, wr_outctl, wr_count, wr_compare, wr_clear, wr_irq_en;
  logic count_tick; // count clock enable
  logic watch_tick; // watch clock enable
  logic watch_mode; // quarter watch rate selected
  logic subactive; // subactive power mode
  timer_evt_s evt; // events of this cycle
  logic ovf_valid, cmp_valid, isrc_valid;
  logic [2:0] clr_req; // clear bits written by software
  logic [2:0] clr_ok; // clears that are allowed now
  logic [31:0] rd_value; // read mux
  clk_sel_e clk_sel;

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  // a write lands only at the edge where waitrequest is seen low
  assign wr_fire = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
  assign lane0 = AVS_BYTEENABLE_IN[0];
  assign wr_ctrl = wr_fire && lane0 && (AVS_ADDRESS_IN == OFS_CTRL);
  assign wr_outctl = wr_fire && lane0 && (AVS_ADDRESS_IN == OFS_OUTCTL);
  assign wr_count = wr_fire && lane0 && (AVS_ADDRESS_IN == OFS_COUNT);
  assign wr_compare = wr_fire && lane0 && (AVS_ADDRESS_IN == OFS_COMPARE);
  assign wr_clear = wr_fire && lane0 && (AVS_ADDRESS_IN == OFS_CLEAR);
  assign wr_irq_en = wr_fire && lane0 && (AVS_ADDRESS_IN == OFS_IRQ_EN);

  // control fields
  assign clk_sel = clk_sel_e'(ctrl_reg[CTRL_SEL_LSB +: 2]);
  assign watch_mode = (clk_sel == CLK_WATCH_QUARTER);
  assign subactive = ctrl_reg[CTRL_SUBACT_BIT];

  // --------------------------------------------------------------------------
  // count clock
  // --------------------------------------------------------------------------
  count_clock_gen u_count_clock_gen (
    .clk_in(REF_CLK_IN),
    .resetn_in(RESETN_IN),
    .run_in(ctrl_reg[CTRL_RUN_BIT]),
    .sel_in(clk_sel),
    .count_tick_out(count_tick),
    .watch_tick_out(watch_tick)
  );

  // --------------------------------------------------------------------------
  // avalon slave: one wait cycle, then the answer
  // --------------------------------------------------------------------------
  // waitrequest drops for exactly one cycle per request
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      AVS_WAITREQUEST_OUT <= 1'b1;
    end else if (!AVS_WAITREQUEST_OUT) begin
      // answer given, back to waiting
      AVS_WAITREQUEST_OUT <= 1'b1;
    end else begin
      AVS_WAITREQUEST_OUT <= !(AVS_READ_IN || AVS_WRITE_IN);
    end
  end

  // read mux, unmapped and write-only offsets read zero
  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (AVS_ADDRESS_IN)
      OFS_CTRL: rd_value = {24'h000000, ctrl_reg};
      OFS_OUTCTL: rd_value = {31'h0000_0000, low_half_out_level_bit};
      OFS_COUNT: rd_value = {24'h000000, low_half_counter};
      OFS_COMPARE: rd_value = {24'h000000, low_half_compare_value};
      OFS_STATUS: rd_value = {29'h0000_0000, flags_reg};
      OFS_IRQ_EN: rd_value = {29'h0000_0000, irq_en_reg};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  // read data captured as waitrequest drops, stands at the answer edge
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      AVS_READDATA_OUT <= 32'h0000_0000;
    end else if (AVS_READ_IN && AVS_WAITREQUEST_OUT) begin
      AVS_READDATA_OUT <= rd_value;
    end
  end

  // --------------------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------------------
  // control and enables
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ctrl_reg <= CTRL_RESET;
      irq_en_reg <= FLAGS_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= {3'h0, AVS_WRITEDATA_IN[4:0]};
      end
      if (wr_irq_en) begin
        irq_en_reg <= AVS_WRITEDATA_IN[2:0];
      end
    end
  end

  // compare value register
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      low_half_compare_value <= COMPARE_RESET;
    end else if (wr_compare) begin
      low_half_compare_value <= AVS_WRITEDATA_IN[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // counter and events
  // --------------------------------------------------------------------------
  // counter, a software write wins over the count edge
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      low_half_counter <= COUNT_RESET;
    end else if (wr_count) begin
      low_half_counter <= AVS_WRITEDATA_IN[7:0];
    end else if (count_tick) begin
      low_half_counter <= low_half_counter + 8'h01;
    end
  end

  // events exist only on a count edge; the old compare value is
  // used, so equal new data never matches here
  always_comb begin
    evt.cmp = count_tick && (low_half_counter == low_half_compare_value);
    if (wr_compare) begin
      evt.cmp = 1'b0;
    end
    evt.ovf = count_tick && (low_half_counter == COUNT_MAX) && !wr_count;
    evt.isrc = evt.cmp || evt.ovf;
  end

  // --------------------------------------------------------------------------
  // signal validity windows
  // --------------------------------------------------------------------------
  // in watch mode the windows are counted in watch cycles; on the
  // system clock a signal lives only in its own cycle
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ovf_left_reg <= 2'h0;
      cmp_left_reg <= 2'h0;
      isrc_left_reg <= 2'h0;
    end else begin
      if (evt.ovf && watch_mode) begin
        ovf_left_reg <= WATCH_EVT_TICKS;
      end else if (watch_tick && ovf_left_reg != 2'h0) begin
        ovf_left_reg <= ovf_left_reg - 2'h1;
      end
      if (evt.cmp && watch_mode) begin
        cmp_left_reg <= WATCH_EVT_TICKS;
      end else if (watch_tick && cmp_left_reg != 2'h0) begin
        cmp_left_reg <= cmp_left_reg - 2'h1;
      end
      if (evt.isrc && watch_mode) begin
        isrc_left_reg <= WATCH_ISRC_TICKS;
      end else if (watch_tick && isrc_left_reg != 2'h0) begin
        isrc_left_reg <= isrc_left_reg - 2'h1;
      end
    end
  end

  assign ovf_valid = evt.ovf || (ovf_left_reg != 2'h0);
  assign cmp_valid = evt.cmp || (cmp_left_reg != 2'h0);
  assign isrc_valid = evt.isrc || (isrc_left_reg != 2'h0);

  // --------------------------------------------------------------------------
  // sticky flags
  // --------------------------------------------------------------------------
  assign clr_req = wr_clear ? AVS_WRITEDATA_IN[2:0] : 3'h0;

  // which clears are honoured now
  always_comb begin
    clr_ok = clr_req;
    if (!subactive) begin
      clr_ok[ST_OVF_BIT] = clr_req[ST_OVF_BIT] && !ovf_valid;
      clr_ok[ST_CMP_BIT] = clr_req[ST_CMP_BIT] && !cmp_valid;
    end
    if (subactive) begin
      clr_ok = clr_req;
    end
  end

  // set wins over clear in the same cycle
  always_comb begin
    flags_next = flags_reg & ~clr_ok;
    flags_next = flags_next | evt;
    if (!subactive && isrc_valid && clr_ok[ST_IRQ_BIT]) begin
      flags_next[ST_IRQ_BIT] = 1'b1;
    end
  end

  // the software side waits and reads status before clearing; a
  // clear sent too early is simply lost
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      flags_reg <= FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // level interrupt from enabled flags, one cycle behind
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(flags_reg & irq_en_reg);
    end
  end

  // --------------------------------------------------------------------------
  // output pin
  // --------------------------------------------------------------------------
  // level bit and pin, a register write beats a toggle
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      low_half_out_level_bit <= 1'b0;
      LOW_HALF_TOGGLE_OUT_PIN_OUT <= 1'b0;
    end else if (wr_outctl) begin
      low_half_out_level_bit <= AVS_WRITEDATA_IN[OUTCTL_LEVEL_BIT];
      LOW_HALF_TOGGLE_OUT_PIN_OUT <= AVS_WRITEDATA_IN[OUTCTL_LEVEL_BIT];
    end else if (evt.cmp && ctrl_reg[CTRL_TOGGLE_BIT]) begin
      LOW_HALF_TOGGLE_OUT_PIN_OUT <= !LOW_HALF_TOGGLE_OUT_PIN_OUT;
    end
  end

endmodule : timer_compare_overflow_contention

// >>> dv/timer_cmp_checker.sv
`timescale 1ns/1ps
// ------------------------------------
// port level checks of the timer block
// ------------------------------------
module timer_cmp_checker
  import timer_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic [4:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic AVS_WAITREQUEST_OUT,
  input wire logic LOW_HALF_TOGGLE_OUT_PIN_OUT,
  input wire logic IRQ_OUT
);
  // accepted write with the low byte enabled
  wire wr_ok = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_BYTEENABLE_IN[0];
  // accepted read
  wire rd_ok = AVS_READ_IN && !AVS_WAITREQUEST_OUT;
  // accepted write of the output level
  wire lvl_wr = wr_ok && AVS_ADDRESS_IN == OFS_OUTCTL;
  logic tog_shadow; // toggle mode as last written
  logic [2:0] en_shadow; // interrupt enables as last written
  // toggle mode follows accepted control writes
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      tog_shadow <= 1'b0;
    end else if (wr_ok && AVS_ADDRESS_IN == OFS_CTRL) begin
      tog_shadow <= AVS_WRITEDATA_IN[CTRL_TOGGLE_BIT];
    end
  end
  // enables follow accepted enable writes
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      en_shadow <= 3'h0;
    end else if (wr_ok && AVS_ADDRESS_IN == OFS_IRQ_EN) begin
      en_shadow <= AVS_WRITEDATA_IN[2:0];
    end
  end
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // request still waiting for its answer
  sequence s_req_wait;
    (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT;
  endsequence
  // level write taken, then pin shows it
  sequence s_lvl_taken;
    lvl_wr ##1 1'b1;
  endsequence
  a_wait_one_cycle: assert property (s_req_wait |=> !AVS_WAITREQUEST_OUT)
    else $error("waitrequest not low one cycle after a request");
  a_wait_single_low: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
    else $error("waitrequest low for more than one cycle");
  a_wait_has_cause: assert property (!AVS_WAITREQUEST_OUT |->
      $past(AVS_READ_IN) || $past(AVS_WRITE_IN))
    else $error("waitrequest low without a request");
  a_read_upper_zero: assert property (rd_ok |-> AVS_READDATA_OUT[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_clear_reads_zero: assert property (rd_ok && (AVS_ADDRESS_IN == OFS_CLEAR ||
      AVS_ADDRESS_IN > OFS_IRQ_EN) |-> AVS_READDATA_OUT == 32'h0)
    else $error("clear or unmapped read not zero");
  a_status_bits_only: assert property (rd_ok && AVS_ADDRESS_IN == OFS_STATUS |->
      AVS_READDATA_OUT[7:3] == 5'h0)
    else $error("status read has unused bits set");
  a_level_write_wins: assert property (s_lvl_taken |->
      LOW_HALF_TOGGLE_OUT_PIN_OUT == $past(AVS_WRITEDATA_IN[OUTCTL_LEVEL_BIT]))
    else $error("pin does not show the written level");
  a_pin_held: assert property (!tog_shadow && !$past(tog_shadow) && !$past(lvl_wr) |->
      $stable(LOW_HALF_TOGGLE_OUT_PIN_OUT))
    else $error("pin changed without toggle mode or level write");
  a_irq_masked: assert property (en_shadow == 3'h0 && $past(en_shadow) == 3'h0 &&
      $past(en_shadow, 2) == 3'h0 |-> !IRQ_OUT)
    else $error("interrupt high with all enables off");
endmodule : timer_cmp_checker

bind timer_compare_overflow_contention timer_cmp_checker u_chk (
  .REF_CLK_IN(REF_CLK_IN), .RESETN_IN(RESETN_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
  .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
  .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
  .AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
  .LOW_HALF_TOGGLE_OUT_PIN_OUT(LOW_HALF_TOGGLE_OUT_PIN_OUT), .IRQ_OUT(IRQ_OUT)
);

// >>> dv/tb_timer_compare_overflow_contention.sv
`timescale 1ns/1ps
// ---------------------------------
// directed bench for the timer block
// ---------------------------------
module tb_timer_compare_overflow_contention
  import timer_pkg::*;
;
  logic ref_clk; // system clock
  logic resetn; // active low reset
  logic [4:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [3:0] ben;
  logic [31:0] rdata;
  logic waitreq;
  logic pin;
  logic irq;
  int error_cnt;
  int checks_done;
  int t0; // edges from run to first toggle, plus one
  logic [31:0] q; // last read data

  timer_compare_overflow_contention dut (
    .REF_CLK_IN(ref_clk), .RESETN_IN(resetn), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(ben),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
    .LOW_HALF_TOGGLE_OUT_PIN_OUT(pin), .IRQ_OUT(irq)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // one bus cycle, held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d,
      input logic [3:0] e);
    int n;
    n = 0;
    @(posedge ref_clk);
    addr <= a;
    wdata <= {24'h0, d};
    ben <= e;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitreq !== 1'b0);
    // seen with waitrequest high, answered exactly one edge later
    check("bus wait cycles", n, 32'h2);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : xfer

  task automatic wreg(input logic [4:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask : wreg

  task automatic rchk(input string what, input logic [4:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00, 4'hF);
    check(what, q, {24'h0, e});
  endtask : rchk

  // stopped timer with fresh flags and pin low
  task automatic load(input logic [7:0] c, input logic [7:0] m);
    wreg(OFS_CTRL, 8'h02);
    wreg(OFS_CLEAR, 8'h07);
    wreg(OFS_COUNT, c);
    wreg(OFS_COMPARE, m);
    wreg(OFS_OUTCTL, 8'h00);
  endtask : load

  // match and wrap on the same tick, run at system rate
  task automatic arm();
    load(8'hF8, 8'hFF);
    wreg(OFS_IRQ_EN, 8'h02);
    wreg(OFS_CTRL, 8'h03);
  endtask : arm

  // write landing on the edge of the match tick
  task automatic hit(input logic [4:0] a, input logic [7:0] d);
    arm();
    repeat (t0 - 4) @(posedge ref_clk);
    wreg(a, d);
  endtask : hit

  // stop, then judge flags, pin and interrupt
  task automatic judge(input string nm, input logic [7:0] st, input logic p, input logic i);
    repeat (4) @(posedge ref_clk);
    wreg(OFS_CTRL, 8'h02);
    rchk({nm, " status"}, OFS_STATUS, st);
    check({nm, " pin"}, {31'h0, pin}, {31'h0, p});
    check({nm, " irq"}, {31'h0, irq}, {31'h0, i});
    $display("test %s done", nm);
  endtask : judge

  // poll until the match flag shows; bounded
  task automatic wait_match();
    int n;
    n = 0;
    do begin
      xfer(1'b0, OFS_STATUS, 8'h00, 4'hF);
      n++;
    end while (q[ST_CMP_BIT] !== 1'b1 && n < 3000);
    // an exhausted poll counts as a mismatch
    check("match seen", {31'h0, q[ST_CMP_BIT]}, 32'h1);
  endtask : wait_match

  task automatic t_reset();
    logic [4:0] a [8] = '{OFS_CTRL, OFS_OUTCTL, OFS_COUNT, OFS_COMPARE, OFS_STATUS,
      OFS_CLEAR, OFS_IRQ_EN, 5'h1C};
    logic [7:0] e [8] = '{CTRL_RESET, 8'h00, COUNT_RESET, COMPARE_RESET, 8'h00, 8'h00,
      8'h00, 8'h00};
    check("reset pin", {31'h0, pin}, 32'h0);
    check("reset irq", {31'h0, irq}, 32'h0);
    foreach (a[k]) begin
      rchk("reset value", a[k], e[k]);
    end
    // writes without the low byte, or off the map, change nothing
    xfer(1'b1, OFS_COMPARE, 8'h12, 4'h0);
    rchk("masked write", OFS_COMPARE, COMPARE_RESET);
    wreg(5'h1C, 8'h55);
    rchk("unmapped write", 5'h1C, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_calib();
    arm();
    t0 = 0;
    while (pin === 1'b0 && t0 < 40) begin
      @(negedge ref_clk);
      t0++;
    end
    judge("plain match", 8'h07, 1'b1, 1'b1);
    wreg(OFS_CLEAR, 8'h07);
    rchk("flags cleared", OFS_STATUS, 8'h00);
    check("irq released", {31'h0, irq}, 32'h0);
  endtask : t_calib

  task automatic t_collide();
    hit(OFS_COMPARE, 8'h80);
    judge("compare write", 8'h05, 1'b0, 1'b0);
    hit(OFS_COUNT, 8'h40);
    judge("count write", 8'h06, 1'b1, 1'b1);
    hit(OFS_OUTCTL, 8'h00);
    judge("level write", 8'h07, 1'b0, 1'b1);
  endtask : t_collide

  task automatic t_stopped();
    load(8'h20, 8'h20);
    wreg(OFS_CTRL, 8'h0F);
    repeat (30) @(posedge ref_clk);
    judge("stopped clock", 8'h00, 1'b0, 1'b0);
    wreg(OFS_CTRL, 8'h07);
    repeat (30) @(posedge ref_clk);
    judge("divided clock", 8'h06, 1'b1, 1'b1);
  endtask : t_stopped

  // watch quarter rate: source one watch cycle wide, events two
  task automatic t_watch();
    load(8'h00, 8'h00);
    wreg(OFS_CTRL, 8'h0B);
    wait_match();
    wreg(OFS_CLEAR, 8'h06);
    rchk("clear in both windows", OFS_STATUS, 8'h06);
    repeat (1800) @(posedge ref_clk);
    wreg(OFS_CLEAR, 8'h06);
    rchk("clear after source", OFS_STATUS, 8'h02);
    // software side: wait out the window, read status, then clear
    repeat (900) @(posedge ref_clk);
    rchk("status before clear", OFS_STATUS, 8'h02);
    wreg(OFS_CLEAR, 8'h02);
    rchk("clear after match", OFS_STATUS, 8'h00);
    judge("watch rate", 8'h00, 1'b1, 1'b0);
  endtask : t_watch

  task automatic t_subactive();
    load(8'h00, 8'h00);
    wreg(OFS_CTRL, 8'h1B);
    wait_match();
    wreg(OFS_CLEAR, 8'h07);
    rchk("subactive clear", OFS_STATUS, 8'h00);
    judge("subactive", 8'h00, 1'b1, 1'b0);
  endtask : t_subactive

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // free running system clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // hang guard, well past the longest expected run
  initial begin
    repeat (60000) @(posedge ref_clk);
    error_cnt++;
    $display("unexpected run length: expected finish seen timeout");
    summarize();
  end

  initial begin
    resetn = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 5'h00;
    wdata = 32'h0;
    ben = 4'h0;
    error_cnt = 0;
    checks_done = 0;
    t0 = 0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_calib();
    t_collide();
    t_stopped();
    t_watch();
    t_subactive();
    summarize();
  end
endmodule : tb_timer_compare_overflow_contention
